// ===== src/jsr_scan_regs.sv
// Scan register set and instruction decoder behind the test access port.
`timescale 1ns/1ps
`include "jsr_defs.svh"

module jsr_scan_regs #(
   parameter logic [31:0] DEVICE_ID = 32'h0a5a5001 // Arbitrary identity value.
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic tap_reset,
   input wire logic tap_capture_dr,
   input wire logic tap_shift_dr,
   input wire logic tap_update_dr,
   input wire logic tap_capture_ir,
   input wire logic tap_shift_ir,
   input wire logic tap_update_ir,
   input wire logic tap_run_idle,
   input wire logic tdi,
   output logic tdo,
   input wire logic [3:0] design_chain_tdo,
   input wire logic converter_tdo,
   input wire logic cfg_done,
   input wire logic cfg_init_complete,
   input wire logic isc_done,
   input wire logic [31:0] cfg_read_word,
   input wire logic [63:0] unique_id,
   input wire logic [3:0] core_out,
   input wire logic [3:0] core_oe,
   input wire logic [4:0] pad_in,
   output logic [3:0] pad_out,
   output logic [3:0] pad_oe,
   output logic [3:0] design_chain_sel,
   output logic converter_port_access,
   output logic insys_cfg_write,
   output logic [31:0] cfg_write_word,
   output logic cfg_write_stb,
   output logic scan_full_reconfig,
   output logic scan_clocked_startup,
   output logic scan_clocked_shutdown,
   output logic insys_shutdown_req,
   output logic insys_startup_req,
   output logic insys_cfg_active,
   output logic secure_state,
   output logic pulsed_external_test,
   output logic training_external_test
);

   // All state lives in one packed record; st_next is its value for the next edge.
   jsr_pkg::jsr_state_type st_reg;
   jsr_pkg::jsr_state_type st_next;
   // Decoded view of the instruction in force: register, length and modes.
   jsr_pkg::jsr_sel_type sel;
   logic [6:0] dr_len;
   logic [5:0] dr_top;
   logic [1:0] chain_idx;
   logic ext_mode;
   logic float_mode;
   logic reserved_op;
   // Boundary capture vector, next pad drive and the shifted data register.
   logic [12:0] bsr_capture;
   logic [3:0] drive_out;
   logic [3:0] drive_oe;
   logic [63:0] shifted;

   // Per pad cell: control cell nearest the output end, then output, then input.
   // Bit 0 of the chain sits nearest the serial output.
   generate
      for (genvar p = 0; p < `JSR_PADS; p++) begin : g_pad
         assign bsr_capture[3*p] = st_reg.pad_oe[p];
         assign bsr_capture[3*p+1] = st_reg.pad_out[p];
         assign bsr_capture[3*p+2] = pad_in[p];
         assign drive_out[p] = ext_mode ? st_reg.upd[3*p+1] : core_out[p];
         assign drive_oe[p] = ext_mode ? st_reg.upd[3*p] : (core_oe[p] & ~float_mode);
      end
   endgenerate
   // The input-only pad adds just its input cell at the input end.
   assign bsr_capture[12] = pad_in[4];

   // Decode the active instruction into a data register, its length and modes.
   always_comb begin
      sel = jsr_pkg::JSR_SEL_BYPASS;
      dr_len = {1'b0, `JSR_LEN_BYPASS};
      chain_idx = 2'd0;
      ext_mode = 1'b0;
      float_mode = 1'b0;
      reserved_op = 1'b0;
      case (st_reg.ir)
         `JSR_OP_EXTEST, `JSR_OP_PULSED_EXT, `JSR_OP_TRAINING_EXT: begin
            sel = jsr_pkg::JSR_SEL_BOUNDARY;
            ext_mode = 1'b1;
         end
         `JSR_OP_SAMPLE: begin
            sel = jsr_pkg::JSR_SEL_BOUNDARY;
         end
         `JSR_OP_CHAIN_ONE: begin
            sel = jsr_pkg::JSR_SEL_CHAIN;
         end
         `JSR_OP_CHAIN_TWO: begin
            sel = jsr_pkg::JSR_SEL_CHAIN;
            chain_idx = 2'd1;
         end
         `JSR_OP_CHAIN_THREE: begin
            sel = jsr_pkg::JSR_SEL_CHAIN;
            chain_idx = 2'd2;
         end
         `JSR_OP_CHAIN_FOUR: begin
            sel = jsr_pkg::JSR_SEL_CHAIN;
            chain_idx = 2'd3;
         end
         `JSR_OP_CFG_READ, `JSR_OP_CFG_WRITE: begin
            sel = jsr_pkg::JSR_SEL_CONFIG;
         end
         `JSR_OP_USER_ID: begin
            sel = jsr_pkg::JSR_SEL_USER_ID;
         end
         `JSR_OP_DEVICE_ID: begin
            sel = jsr_pkg::JSR_SEL_DEVICE_ID;
         end
         `JSR_OP_FLOAT_PINS: begin
            float_mode = 1'b1;
         end
         `JSR_OP_UID_SHORT: begin
            sel = jsr_pkg::JSR_SEL_UID_SHORT;
         end
         `JSR_OP_UID_LONG: begin
            sel = jsr_pkg::JSR_SEL_UID_LONG;
         end
         `JSR_OP_CONVERTER: begin
            sel = jsr_pkg::JSR_SEL_CONVERTER;
         end
         `JSR_OP_FULL_RECONFIG, `JSR_OP_STARTUP, `JSR_OP_SHUTDOWN,
         `JSR_OP_ISC_BEGIN, `JSR_OP_ISC_WRITE, `JSR_OP_SEC_TOGGLE,
         `JSR_OP_INSYS_NO_OPERATION, `JSR_OP_ISC_FINISH, `JSR_OP_BYPASS: begin
            sel = jsr_pkg::JSR_SEL_BYPASS;
         end
         default: begin
            reserved_op = 1'b1;
         end
      endcase
      // The length of the chosen register sets where the serial input enters.
      case (sel)
         jsr_pkg::JSR_SEL_BOUNDARY: dr_len = 7'(`JSR_BSR_LEN);
         jsr_pkg::JSR_SEL_DEVICE_ID, jsr_pkg::JSR_SEL_USER_ID,
         jsr_pkg::JSR_SEL_CONFIG: dr_len = {1'b0, `JSR_LEN_WORD};
         jsr_pkg::JSR_SEL_UID_SHORT: dr_len = {1'b0, `JSR_LEN_UID_SHORT};
         jsr_pkg::JSR_SEL_UID_LONG: dr_len = `JSR_LEN_UID_LONG;
         default: dr_len = {1'b0, `JSR_LEN_BYPASS};
      endcase
   end

   // Shift by one toward the output end; the input bit enters at the top cell.
   // Upper bits of a short register stay zero and never reach the output.
   assign dr_top = 6'(dr_len - 7'd1);
   always_comb begin
      shifted = {1'b0, st_reg.dr[63:1]};
      shifted[dr_top] = tdi;
   end

   // Next-state logic for the scan registers, actions and bus slave.
   always_comb begin
      st_next = st_reg;
      st_next.cfg_stb = 1'b0;
      st_next.reconfig = 1'b0;
      st_next.startup_step = 1'b0;
      st_next.shutdown_step = 1'b0;
      st_next.isc_shutdown = 1'b0;
      st_next.isc_startup = 1'b0;
      st_next.wb_ack = 1'b0;
      // Instruction path. Actions fire only at the update step, so an instruction
      // that stays in force for a long time never repeats them.
      if (tap_reset) begin
         st_next.ir = `JSR_OP_DEVICE_ID;
      end else if (tap_capture_ir) begin
         st_next.ir_shift = {cfg_done, cfg_init_complete, st_reg.isc_enabled,
                             isc_done, `JSR_IR_CAPTURE_LOW};
      end else if (tap_shift_ir) begin
         st_next.ir_shift = {tdi, st_reg.ir_shift[5:1]};
      end else if (tap_update_ir) begin
         st_next.ir = st_reg.ir_shift;
         if (st_reg.ir_shift == `JSR_OP_FULL_RECONFIG) begin
            st_next.reconfig = 1'b1;
         end
         if (st_reg.ir_shift == `JSR_OP_ISC_BEGIN) begin
            st_next.isc_enabled = 1'b1;
            st_next.isc_shutdown = 1'b1;
         end
         if (st_reg.ir_shift == `JSR_OP_ISC_FINISH) begin
            st_next.isc_enabled = 1'b0;
            st_next.isc_startup = 1'b1;
         end
         if (st_reg.ir_shift == `JSR_OP_SEC_TOGGLE) begin
            st_next.secure = ~st_reg.secure;
         end
      end
      // Data path. Only the boundary register has update latches; the others
      // act on their own update step or not at all.
      if (tap_capture_dr) begin
         case (sel)
            jsr_pkg::JSR_SEL_BOUNDARY: st_next.dr = {51'h0, bsr_capture};
            jsr_pkg::JSR_SEL_DEVICE_ID: st_next.dr = {32'h0, DEVICE_ID[31:1], 1'b1};
            jsr_pkg::JSR_SEL_USER_ID: st_next.dr = {32'h0, st_reg.usercode};
            jsr_pkg::JSR_SEL_CONFIG: st_next.dr = {32'h0, cfg_read_word};
            jsr_pkg::JSR_SEL_UID_SHORT: st_next.dr = {7'h0, unique_id[56:0]};
            jsr_pkg::JSR_SEL_UID_LONG: st_next.dr = unique_id;
            default: st_next.dr = 64'h0;
         endcase
      end else if (tap_shift_dr) begin
         st_next.dr = shifted;
      end else if (tap_update_dr) begin
         if (sel == jsr_pkg::JSR_SEL_BOUNDARY) begin
            st_next.upd = st_reg.dr[12:0];
         end
         if (st_reg.ir == `JSR_OP_CFG_WRITE) begin
            st_next.cfg_word = st_reg.dr[31:0];
            st_next.cfg_stb = 1'b1;
         end
      end
      // Scan-clocked shutdown advances one step per idle clock; startup does so only while startup_sel is set.
      if (tap_run_idle && st_reg.ir == `JSR_OP_STARTUP && st_reg.startup_sel) begin
         st_next.startup_step = 1'b1;
      end
      if (tap_run_idle && st_reg.ir == `JSR_OP_SHUTDOWN) begin
         st_next.shutdown_step = 1'b1;
      end
      // Level outputs follow the instruction that is now in force.
      // Under external test, pads move one cycle after a latch or instruction change, never mid-shift.
      st_next.pad_out = drive_out;
      st_next.pad_oe = drive_oe;
      st_next.chain_sel = (sel == jsr_pkg::JSR_SEL_CHAIN) ? 4'(4'h1 << chain_idx) : 4'h0;
      st_next.conv_sel = (sel == jsr_pkg::JSR_SEL_CONVERTER);
      st_next.cfg_write_en = (st_reg.ir == `JSR_OP_ISC_WRITE);
      st_next.pulse_en = (st_reg.ir == `JSR_OP_PULSED_EXT);
      st_next.train_en = (st_reg.ir == `JSR_OP_TRAINING_EXT);
      // Serial output: head of whichever register sits between input and output.
      // During an instruction scan the instruction register owns the output.
      if (tap_shift_ir || tap_capture_ir) begin
         st_next.tdo = st_next.ir_shift[0];
      end else if (sel == jsr_pkg::JSR_SEL_CHAIN) begin
         st_next.tdo = design_chain_tdo[chain_idx];
      end else if (sel == jsr_pkg::JSR_SEL_CONVERTER) begin
         st_next.tdo = converter_tdo;
      end else begin
         st_next.tdo = st_next.dr[0];
      end
      // Bus slave: answer one cycle after the request, zero for unmapped reads.
      if (wb_cyc_i && wb_stb_i && !st_reg.wb_ack) begin
         st_next.wb_ack = 1'b1;
         st_next.wb_dat = 32'h0;
         if (wb_adr_i == `JSR_WB_CTRL) begin
            st_next.wb_dat = {31'h0, st_reg.startup_sel};
         end else if (wb_adr_i == `JSR_WB_USERCODE) begin
            st_next.wb_dat = st_reg.usercode;
         end else if (wb_adr_i == `JSR_WB_STATUS) begin
            st_next.wb_dat = {22'h0, reserved_op, st_reg.secure,
                              st_reg.isc_enabled, 1'b0, st_reg.ir};
         end else if (wb_adr_i == `JSR_WB_CFG_WORD) begin
            st_next.wb_dat = st_reg.cfg_word;
         end
      end
      // Writes land on the edge at which the master sees the acknowledge, so a
      // request withdrawn before that edge leaves the registers untouched.
      if (wb_cyc_i && wb_stb_i && wb_we_i && st_reg.wb_ack) begin
         if (wb_adr_i == `JSR_WB_CTRL) begin
            if (wb_sel_i[0]) begin
               st_next.startup_sel = wb_dat_i[0];
            end
         end else if (wb_adr_i == `JSR_WB_USERCODE) begin
            for (int b = 0; b < 4; b++) begin
               if (wb_sel_i[b]) begin
                  st_next.usercode[8*b +: 8] = wb_dat_i[8*b +: 8];
               end
            end
         end
      end
   end

   // One register holds all state; reset gives the defined idle values.
   // Reset is synchronous; the instruction falls back to the identity read.
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_reg <= '0;
         st_reg.ir <= `JSR_OP_DEVICE_ID;
         st_reg.usercode <= `JSR_USERCODE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Every output is a field of the state register.
   // Registered outputs keep pad and strobe lines free of decode glitches.
   assign wb_dat_o = st_reg.wb_dat;
   assign wb_ack_o = st_reg.wb_ack;
   assign tdo = st_reg.tdo;
   assign pad_out = st_reg.pad_out;
   assign pad_oe = st_reg.pad_oe;
   assign design_chain_sel = st_reg.chain_sel;
   assign converter_port_access = st_reg.conv_sel;
   assign insys_cfg_write = st_reg.cfg_write_en;
   assign cfg_write_word = st_reg.cfg_word;
   assign cfg_write_stb = st_reg.cfg_stb;
   assign scan_full_reconfig = st_reg.reconfig;
   assign scan_clocked_startup = st_reg.startup_step;
   assign scan_clocked_shutdown = st_reg.shutdown_step;
   assign insys_shutdown_req = st_reg.isc_shutdown;
   assign insys_startup_req = st_reg.isc_startup;
   assign insys_cfg_active = st_reg.isc_enabled;
   assign secure_state = st_reg.secure;
   assign pulsed_external_test = st_reg.pulse_en;
   assign training_external_test = st_reg.train_en;

endmodule

// ===== src/jsr_defs.svh
// Constants for the scan register set: opcodes, lengths, bus offsets, reset values.
`ifndef JSR_DEFS_SVH
`define JSR_DEFS_SVH
`define JSR_IR_W 6
`define JSR_IR_CAPTURE_LOW 2'b01
`define JSR_OP_EXTEST 6'b100110
`define JSR_OP_PULSED_EXT 6'b111100
`define JSR_OP_TRAINING_EXT 6'b111101
`define JSR_OP_SAMPLE 6'b000001
`define JSR_OP_CHAIN_ONE 6'b000010
`define JSR_OP_CHAIN_TWO 6'b000011
`define JSR_OP_CHAIN_THREE 6'b100010
`define JSR_OP_CHAIN_FOUR 6'b100011
`define JSR_OP_CFG_READ 6'b000100
`define JSR_OP_CFG_WRITE 6'b000101
`define JSR_OP_USER_ID 6'b001000
`define JSR_OP_DEVICE_ID 6'b001001
`define JSR_OP_FLOAT_PINS 6'b001010
`define JSR_OP_FULL_RECONFIG 6'b001011
`define JSR_OP_STARTUP 6'b001100
`define JSR_OP_SHUTDOWN 6'b001101
`define JSR_OP_CONVERTER 6'b110111
`define JSR_OP_ISC_BEGIN 6'b010000
`define JSR_OP_ISC_WRITE 6'b010001
`define JSR_OP_SEC_TOGGLE 6'b010010
`define JSR_OP_UID_SHORT 6'b010111
`define JSR_OP_UID_LONG 6'b110010
`define JSR_OP_INSYS_NO_OPERATION 6'b010100
`define JSR_OP_ISC_FINISH 6'b010110
`define JSR_OP_BYPASS 6'b111111
`define JSR_PADS 4
`define JSR_BSR_LEN 13
`define JSR_LEN_BYPASS 6'd1
`define JSR_LEN_WORD 6'd32
`define JSR_LEN_UID_SHORT 6'd57
`define JSR_LEN_UID_LONG 7'd64
`define JSR_WB_CTRL 8'h00
`define JSR_WB_USERCODE 8'h04
`define JSR_WB_STATUS 8'h08
`define JSR_WB_CFG_WORD 8'h0c
`define JSR_USERCODE_RST 32'hffffffff
`endif

// ===== src/jsr_pkg.sv
// Types shared by the scan register set.
package jsr_pkg;
   typedef enum logic [3:0] {
      JSR_SEL_BYPASS = 4'h0,
      JSR_SEL_BOUNDARY = 4'h1,
      JSR_SEL_DEVICE_ID = 4'h2,
      JSR_SEL_USER_ID = 4'h3,
      JSR_SEL_CONFIG = 4'h4,
      JSR_SEL_CHAIN = 4'h5,
      JSR_SEL_UID_SHORT = 4'h6,
      JSR_SEL_UID_LONG = 4'h7,
      JSR_SEL_CONVERTER = 4'h8
   } jsr_sel_type;
   typedef struct packed {
      logic [5:0] ir_shift;
      logic [5:0] ir;
      logic [63:0] dr;
      logic [12:0] upd;
      logic isc_enabled;
      logic secure;
      logic startup_sel;
      logic [31:0] usercode;
      logic [31:0] cfg_word;
      logic cfg_stb;
      logic reconfig;
      logic startup_step;
      logic shutdown_step;
      logic isc_shutdown;
      logic isc_startup;
      logic tdo;
      logic [3:0] pad_out;
      logic [3:0] pad_oe;
      logic [3:0] chain_sel;
      logic conv_sel;
      logic cfg_write_en;
      logic pulse_en;
      logic train_en;
      logic wb_ack;
      logic [31:0] wb_dat;
   } jsr_state_type;
endpackage

// ===== tb/jsr_scan_regs_chk.sv
// Port-level checks for the scan register set.
`timescale 1ns/1ps
module jsr_scan_regs_chk (
   input wire logic mclk,
   input wire logic reset,
   input wire logic tap_capture_ir,
   input wire logic tap_shift_ir,
   input wire logic tap_update_ir,
   input wire logic tap_update_dr,
   input wire logic tap_run_idle,
   input wire logic tdo,
   input wire logic [3:0] design_chain_tdo,
   input wire logic [3:0] design_chain_sel,
   input wire logic cfg_write_stb,
   input wire logic scan_full_reconfig,
   input wire logic scan_clocked_startup,
   input wire logic scan_clocked_shutdown,
   input wire logic insys_shutdown_req,
   input wire logic insys_cfg_active,
   input wire logic secure_state
);
   // All checks use the one clock and rest while reset is high.
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   property p_ir_cap; tap_capture_ir |=> tdo; endproperty
   a_ir_cap: assert property (p_ir_cap) else $error("ir capture low bit not one");
   property p_recfg; scan_full_reconfig |-> $past(tap_update_ir) ##1 !scan_full_reconfig; endproperty
   a_recfg: assert property (p_recfg) else $error("reconfig pulse misplaced");
   property p_isc; insys_shutdown_req |-> $past(tap_update_ir) ##1 insys_cfg_active; endproperty
   a_isc: assert property (p_isc) else $error("shutdown request misplaced");
   property p_start; scan_clocked_startup |-> $past(tap_run_idle); endproperty
   a_start: assert property (p_start) else $error("startup step without idle step");
   property p_shut; scan_clocked_shutdown |-> $past(tap_run_idle); endproperty
   a_shut: assert property (p_shut) else $error("shutdown step without idle step");
   property p_onehot; $onehot0(design_chain_sel); endproperty
   a_onehot: assert property (p_onehot) else $error("two chains selected");
   property p_chain; design_chain_sel[0] && $past(design_chain_sel[0])
      && !$past(tap_capture_ir) && !$past(tap_shift_ir)
      |-> tdo == $past(design_chain_tdo[0]); endproperty
   a_chain: assert property (p_chain) else $error("chain output not passed");
   property p_stb; cfg_write_stb |-> $past(tap_update_dr); endproperty
   a_stb: assert property (p_stb) else $error("config strobe without update");
   property p_sec; $changed(secure_state) |-> $past(tap_update_ir) || $past(tap_update_ir, 2);
   endproperty
   a_sec: assert property (p_sec) else $error("security changed without update");
   // Main scenarios reached.
   c_recfg: cover property (scan_full_reconfig);
   c_stb: cover property (cfg_write_stb);
   c_isc: cover property (insys_shutdown_req);
endmodule
bind jsr_scan_regs jsr_scan_regs_chk i_jsr_scan_regs_chk (.mclk, .reset, .tap_capture_ir, .tap_shift_ir,
   .tap_update_ir, .tap_update_dr, .tap_run_idle, .tdo, .design_chain_tdo, .design_chain_sel,
   .cfg_write_stb, .scan_full_reconfig, .scan_clocked_startup, .scan_clocked_shutdown,
   .insys_shutdown_req, .insys_cfg_active, .secure_state);

// ===== tb/jsr_tap_ctl.sv
// Model of the external test controller stepping the scan port one state a cycle.
`timescale 1ns/1ps
module jsr_tap_ctl (
   input wire logic mclk,
   input wire logic tdo,
   output logic tap_reset,
   output logic tap_capture_dr,
   output logic tap_shift_dr,
   output logic tap_update_dr,
   output logic tap_capture_ir,
   output logic tap_shift_ir,
   output logic tap_update_ir,
   output logic tap_run_idle,
   output logic tdi
);
   // All strobes start low.
   initial begin
      {tap_reset, tap_capture_dr, tap_shift_dr, tap_update_dr} = '0;
      {tap_capture_ir, tap_shift_ir, tap_update_ir, tap_run_idle, tdi} = '0;
   end
   // Capture, len shifts least significant bit first, then update; tdo read mid-cycle.
   task automatic scan(input logic ir, input int len, input logic [63:0] din,
      output logic [63:0] dout);
      dout = '0;
      @(posedge mclk);
      if (ir) tap_capture_ir <= 1'b1; else tap_capture_dr <= 1'b1;
      @(posedge mclk);
      tap_capture_ir <= 1'b0;
      tap_capture_dr <= 1'b0;
      for (int i = 0; i < len; i++) begin
         if (ir) tap_shift_ir <= 1'b1; else tap_shift_dr <= 1'b1;
         tdi <= din[i];
         @(negedge mclk);
         dout[i] = tdo;
         @(posedge mclk);
      end
      tap_shift_ir <= 1'b0;
      tap_shift_dr <= 1'b0;
      tdi <= ~din[len-1]; // A released line shows the inverse of its last bit.
      if (ir) tap_update_ir <= 1'b1; else tap_update_dr <= 1'b1;
      @(posedge mclk);
      tap_update_ir <= 1'b0;
      tap_update_dr <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   // One test-logic-reset step or one run-idle step.
   task automatic step(input logic rst);
      @(posedge mclk);
      if (rst) tap_reset <= 1'b1; else tap_run_idle <= 1'b1;
      @(posedge mclk);
      tap_reset <= 1'b0;
      tap_run_idle <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
endmodule

// ===== tb/jsr_scan_regs_tb.sv
// Self-checking bench for the scan register set.
`timescale 1ns/1ps
`include "jsr_defs.svh"
module jsr_scan_regs_tb;
   localparam logic [31:0] DEV = 32'h1c3e5a70; // Arbitrary identity value.
   logic mclk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tap_reset, tap_capture_dr;
   logic tap_shift_dr, tap_update_dr, tap_capture_ir, tap_shift_ir, tap_update_ir, act;
   logic tap_run_idle, tdi, tdo, converter_tdo, cfg_done, cfg_init_complete, isc_done;
   logic converter_port_access, insys_cfg_write, cfg_write_stb, scan_full_reconfig;
   logic scan_clocked_startup, scan_clocked_shutdown, insys_shutdown_req, insys_startup_req;
   logic insys_cfg_active, secure_state, pulsed_external_test, training_external_test;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, design_chain_tdo, core_out, core_oe, pad_out, pad_oe, design_chain_sel;
   logic [4:0] pad_in;
   logic [19:0] pcnt;
   logic [31:0] wb_dat_i, wb_dat_o, cfg_read_word, cfg_write_word, r5;
   logic [31:0] seed = 32'h0f18;
   logic [63:0] unique_id, exp_q[$], got_q[$];
   string nm_q[$];
   int n_errors = 0, checked = 0, cycles = 0;
   logic [5:0] bops [5] = '{`JSR_OP_BYPASS, `JSR_OP_FLOAT_PINS, `JSR_OP_INSYS_NO_OPERATION, 6'h00, 6'h3e};
   logic [5:0] lops [8] = '{`JSR_OP_CHAIN_ONE, `JSR_OP_CHAIN_TWO, `JSR_OP_CHAIN_THREE,
      `JSR_OP_CHAIN_FOUR, `JSR_OP_CONVERTER, `JSR_OP_ISC_WRITE, `JSR_OP_PULSED_EXT,
      `JSR_OP_TRAINING_EXT};
   jsr_scan_regs #(.DEVICE_ID(DEV)) i_jsr_scan_regs (.mclk, .reset, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tap_reset,
      .tap_capture_dr, .tap_shift_dr, .tap_update_dr, .tap_capture_ir, .tap_shift_ir,
      .tap_update_ir, .tap_run_idle, .tdi, .tdo, .design_chain_tdo, .converter_tdo, .cfg_done,
      .cfg_init_complete, .isc_done, .cfg_read_word, .unique_id, .core_out, .core_oe, .pad_in,
      .pad_out, .pad_oe, .design_chain_sel, .converter_port_access, .insys_cfg_write,
      .cfg_write_word, .cfg_write_stb, .scan_full_reconfig, .scan_clocked_startup,
      .scan_clocked_shutdown, .insys_shutdown_req, .insys_startup_req, .insys_cfg_active,
      .secure_state, .pulsed_external_test, .training_external_test);
   jsr_tap_ctl i_jsr_tap_ctl (.mclk, .tdo, .tap_reset, .tap_capture_dr, .tap_shift_dr,
      .tap_update_dr, .tap_capture_ir, .tap_shift_ir, .tap_update_ir, .tap_run_idle, .tdi);
   // Free-running clock.
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Chain outputs vary every cycle; pulses are counted; a hang is cut short.
   always @(posedge mclk) begin
      r5 = xs();
      {converter_tdo, design_chain_tdo} <= r5[4:0];
      pcnt <= reset ? 20'h0 : pcnt + {3'h0, scan_full_reconfig, 3'h0, scan_clocked_startup,
         3'h0, scan_clocked_shutdown, 3'h0, insys_shutdown_req, 3'h0, insys_startup_req};
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string n, input logic [63:0] w, input logic [63:0] g);
      checked++;
      if (g !== w) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", n, w, g);
      end
   endtask
   // Each result that appears is compared with the oldest expectation.
   initial forever begin
      wait (got_q.size() > 0);
      check(nm_q.pop_front(), exp_q.pop_front(), got_q.pop_front());
   end
   task automatic note(input string n, input logic [63:0] w);
      nm_q.push_back(n);
      exp_q.push_back(w);
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] w);
      logic [31:0] q;
      note(n, w);
      wb(1'b0, a, 4'hf, 32'h0, q);
      got_q.push_back(q);
   endtask
   task automatic ir(input logic [5:0] op);
      logic [63:0] q;
      note("ir capture", {58'h0, cfg_done, cfg_init_complete, act, isc_done, 2'b01});
      i_jsr_tap_ctl.scan(1'b1, 6, {58'h0, op}, q);
      got_q.push_back(q);
   endtask
   task automatic dr(input string n, input int len, input logic [63:0] d, input logic [63:0] w);
      logic [63:0] q;
      note(n, w);
      i_jsr_tap_ctl.scan(1'b0, len, d, q);
      got_q.push_back(q);
   endtask
   task automatic rnd_in();
      logic [31:0] r;
      r = xs();
      @(posedge mclk);
      {cfg_done, cfg_init_complete, isc_done, core_out, core_oe, pad_in} <= r[15:0];
      cfg_read_word <= xs();
      unique_id <= {xs(), xs()};
      @(negedge mclk);
   endtask
   initial begin
      logic [31:0] q;
      logic [63:0] v, w;
      reset = 1'b1;
      act = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
      {cfg_done, cfg_init_complete, isc_done, core_out, core_oe, pad_in} = '0;
      {converter_tdo, design_chain_tdo, cfg_read_word, unique_id} = '0;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      rnd_in();
      // State after reset and an unmapped read.
      rd("status", `JSR_WB_STATUS, 32'h009);
      rd("user code", `JSR_WB_USERCODE, `JSR_USERCODE_RST);
      rd("unmapped", 8'h40, 32'h0);
      ir(`JSR_OP_DEVICE_ID);
      dr("id", 32, 64'h0, {32'h0, DEV | 32'h1});
      // Byte-masked user code write, read back over the scan port.
      wb(1'b1, `JSR_WB_USERCODE, 4'h5, 32'h12345678, q);
      ir(`JSR_OP_USER_ID);
      dr("user id", 32, 64'h0, 64'hff34ff78);
      // Bypass, float and reserved codes give one cleared bit.
      foreach (bops[k]) begin
         ir(bops[k]);
         dr("bypass", 2, 64'h1, 64'h2);
         rd("status", `JSR_WB_STATUS, {22'h0, k > 2, 3'h0, bops[k]});
         if (k == 1) begin
            note("float pads", {core_out, 4'h0});
            got_q.push_back({pad_out, pad_oe});
         end
      end
      i_jsr_tap_ctl.step(1'b1);
      rd("status", `JSR_WB_STATUS, 32'h009);
      // Sample captures pad state; the preload then drives pads under external test.
      v = xs();
      w = {51'h0, pad_in[4], 12'h0};
      for (int p = 0; p < 4; p++) w[3*p +: 3] = {pad_in[p], core_out[p], core_oe[p]};
      ir(`JSR_OP_SAMPLE);
      dr("boundary", 13, v, w);
      ir(`JSR_OP_EXTEST);
      w = 64'h0;
      for (int p = 0; p < 4; p++) {w[p+4], w[p]} = {v[3*p+1], v[3*p]};
      note("extest pads", w);
      got_q.push_back({pad_out, pad_oe});
      // Each chain, port and mode code raises its own level alone.
      foreach (lops[k]) begin
         ir(lops[k]);
         note("levels", 64'h1 << k);
         got_q.push_back({training_external_test, pulsed_external_test, insys_cfg_write,
            converter_port_access, design_chain_sel});
      end
      // Configuration write, readback and unique identifiers.
      v = xs();
      ir(`JSR_OP_CFG_WRITE);
      dr("cfg shift", 32, v, cfg_read_word);
      note("cfg word", v);
      got_q.push_back(cfg_write_word);
      rd("cfg reg", `JSR_WB_CFG_WORD, v[31:0]);
      ir(`JSR_OP_CFG_READ);
      dr("readback", 32, 64'h0, cfg_read_word);
      ir(`JSR_OP_UID_SHORT);
      dr("uid short", 57, 64'h0, unique_id[56:0]);
      ir(`JSR_OP_UID_LONG);
      dr("uid long", 64, 64'h0, unique_id);
      // Actions: startup steps only once the startup clock is the scan clock.
      ir(`JSR_OP_FULL_RECONFIG);
      ir(`JSR_OP_STARTUP);
      i_jsr_tap_ctl.step(1'b0);
      wb(1'b1, `JSR_WB_CTRL, 4'h1, 32'h1, q);
      rd("ctrl", `JSR_WB_CTRL, 32'h1);
      repeat (2) i_jsr_tap_ctl.step(1'b0);
      ir(`JSR_OP_SHUTDOWN);
      i_jsr_tap_ctl.step(1'b0);
      ir(`JSR_OP_ISC_BEGIN);
      act = 1'b1;
      ir(`JSR_OP_SEC_TOGGLE);
      rd("status", `JSR_WB_STATUS, 32'h192);
      ir(`JSR_OP_ISC_FINISH);
      act = 1'b0;
      rd("status", `JSR_WB_STATUS, 32'h116);
      note("pulse counts", 64'h12111);
      got_q.push_back(pcnt);
      repeat (4) @(posedge mclk);
      summarize();
   end
endmodule
